// ==== shared/bfs_pkg.sv ====
// constants shared by the bridge fault supervisor and its serial front end
// assumes a 10 MHz core clock and a free-standing serial clock from the host
//
// Functional notes
// [R1] power-on reset zeroes command and status; bridge and serial output stay high impedance
// [R2] frames accepted and outputs driven only with logic supply valid and enable high
// [R3] driver-supply lockout floats outputs but keeps command and status contents
// [R4] each channel's output follows its command bits gated by its fault status
// [R5] high and low side never on together; a non-overlap gap separates them
// [R6] once enabled a driver stays on until commanded off or faulted off
// [R7] latched faults hold outputs off and status set until host clears them
// [R8] supply lockouts are non-latched; outputs and flag recover on their own
// [R9] commands written during lockout are stored and applied on recovery
// [R10] each frame returns status of the selected channel group; host resends pattern
// [R11] status frozen during a frame, refreshed after frame end unless reset requested
// [R12] reset request clears status and re-enables faulted outputs of selected group
// [R13] reset acts at frame end, starts interval; host waits before next request
// [R14] a fault still present after reset request latches and shuts down again
// [R15] enable low or power-on reset clears the status registers
// [R16] undervoltage floats all outputs and raises supply fail until recovery
// [R17] during undervoltage serial access and settings remain; new settings apply later
// [R18] logic-supply undervoltage turns outputs off, clears command and status
// [R19] overvoltage with lockout enable floats all outputs; supply fail always set
// [R20] overvoltage with lockout enable clear leaves outputs on, flag still set
// [R21] settings written in overvoltage lockout take effect after it ends
// [R22] host should keep overvoltage lockout enable set
// [R23] only an error-free frame loads the last sixteen bits as command
// [R24] latched thermal shutdown clears only by reset request once temperature drops
package bfs_pkg;
  localparam int NCH = 12;
  localparam int GRP = 6;
  // --------------------------------------------------------------------------
  // command word layout
  // --------------------------------------------------------------------------
  localparam int CMD_OVERVOLTAGE_LOCKOUT_ENABLE = 0;
  localparam int CMD_CFG_LSB = 1;
  localparam int CMD_EN_LSB = 7;
  localparam int CMD_UNDERLOAD_SHUTDOWN_ENABLE = 13;
  localparam int CMD_SEL = 14;
  localparam int CMD_SRR = 15;
  localparam logic [15:0] CMD_RST = 16'h0000;
  // --------------------------------------------------------------------------
  // status word layout and per-channel codes
  // --------------------------------------------------------------------------
  localparam int ST_TW = 0;
  localparam int ST_HB_LSB = 1;
  localparam int ST_ULD = 13;
  localparam int ST_PSF = 14;
  localparam int ST_OCS = 15;
  localparam logic [15:0] ST_RST = 16'h0000;
  localparam logic [1:0] HB_OFF = 2'h0;
  localparam logic [1:0] HB_OCS = 2'h1;
  localparam logic [1:0] HB_ULD = 2'h2;
  localparam logic [1:0] HB_ON = 2'h3;
  // --------------------------------------------------------------------------
  // framing: first 16 bits, then multiples of 8
  // --------------------------------------------------------------------------
  localparam logic [4:0] FRAME_MIN = 5'h10;
  localparam logic [4:0] FRAME_WRAP = 5'h17;
  // --------------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int NON_OVERLAP_NS = 1000;
  localparam int SRR_WAIT_NS = 100000;
  localparam int DEAD_W = 4;
  localparam int SRR_W = 10;
  localparam logic [DEAD_W-1:0] DEAD_CYC = DEAD_W'((NON_OVERLAP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [SRR_W-1:0] SRR_CYC = SRR_W'((SRR_WAIT_NS + CLK_NS - 1) / CLK_NS);
endpackage : bfs_pkg

// ==== shared/frame_link_if.sv ====
// carries a received frame and the frozen status between the serial and core domains
// assumes every word is read only while the other side holds it still
interface frame_link_if;
  logic [15:0] rx_word;
  logic frame_ok;
  logic frame_id;
  logic [15:0] status_word;
  logic tsd_flag;
  modport front (output rx_word, output frame_ok, output frame_id,
                 input status_word, input tsd_flag);
  modport core (input rx_word, input frame_ok, input frame_id,
                output status_word, output tsd_flag);
endinterface : frame_link_if

// ==== hdl/spi_link_front.sv ====
// serial front end on the host's clock: shifts in the command, counts bits, shifts status out
// assumes the host idles the serial clock low with chip select high between frames
module spi_link_front (
  // link clock and pins
  input wire logic i_sclk,
  input wire logic i_csb_n,
  input wire logic i_si,
  input wire logic i_nrst,
  output logic o_so,
  // towards the core
  frame_link_if.front lk
);
  typedef struct packed {
    logic [15:0] sh;
    logic [15:0] out;
    logic [4:0] cnt;
    logic id;
  } front_t;
  front_t q;
  front_t n;
  logic first_q;

  // --------------------------------------------------------------------------
  // frame start marker, set while chip select is high
  // --------------------------------------------------------------------------
  always_ff @(posedge i_sclk or posedge i_csb_n) begin
    if (i_csb_n) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  always_comb begin
    n = q;
    n.sh = {q.sh[14:0], i_si};
    if (first_q) begin
      // new frame: restart count, flip id so the core sees a fresh frame
      n.cnt = 5'h01;
      n.id = ~q.id;
      n.out = lk.status_word;
    end else begin
      n.cnt = (q.cnt == bfs_pkg::FRAME_WRAP) ? bfs_pkg::FRAME_MIN : q.cnt + 5'h01;
      n.out = {q.out[14:0], 1'b0};
    end
  end

  always_ff @(posedge i_sclk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // last sixteen bits, valid only at 16 + 8k clocks
  assign lk.rx_word = q.sh;
  assign lk.frame_ok = (q.cnt >= bfs_pkg::FRAME_MIN) && (q.cnt[2:0] == 3'h0); // R23
  assign lk.frame_id = q.id;
  // thermal shutdown shows before the first edge, then the status word
  assign o_so = first_q ? lk.tsd_flag : q.out[15];
endmodule : spi_link_front

// ==== hdl/bridge_fault_supervisor.sv ====
// fault supervision and output control for a twelve-channel half-bridge driver
// assumes fault inputs are already delay-qualified by the analog side and arrive asynchronously
module bridge_fault_supervisor (
  // core clock and power-on reset
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_en,
  // serial link
  input wire logic i_sclk,
  input wire logic i_csb_n,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe_n,
  // supply monitors
  input wire logic i_supply_uv,
  input wire logic i_supply_ov,
  // per-channel fault sensors
  input wire logic [11:0] i_overcurrent,
  input wire logic [11:0] i_underload,
  input wire logic [11:0] i_thermal_warn,
  input wire logic [11:0] i_thermal_sd,
  // bridge drivers
  output logic [11:0] o_high_side_switch,
  output logic [11:0] o_low_side_switch,
  output logic [11:0] o_bridge_oe_n,
  // visible state
  output logic o_supply_fail_flag,
  output logic o_srr_busy
);
  localparam int NCH = bfs_pkg::NCH;
  localparam int GRP = bfs_pkg::GRP;

  typedef struct packed {
    logic [1:0] cs_s;
    logic [1:0] en_s;
    logic [1:0] uv_s;
    logic [1:0] ov_s;
    logic [1:0][11:0] oc_s;
    logic [1:0][11:0] ul_s;
    logic [1:0][11:0] tw_s;
    logic [1:0][11:0] ts_s;
    logic cs_prev;
    logic seen_id;
    logic [11:0] en_cmd;
    logic [11:0] dir_cmd;
    logic underload_shutdown_enable;
    logic overvoltage_lockout_enable;
    logic sel;
    logic [11:0] ocs_l;
    logic [11:0] uld_l;
    logic [11:0] tsd_l;
    logic [15:0] snap;
    logic snap_tsd;
    logic hold;
    logic [bfs_pkg::SRR_W-1:0] srr_cnt;
    logic [11:0] drv_hs;
    logic [11:0] drv_ls;
    logic [11:0][bfs_pkg::DEAD_W-1:0] dt;
    logic so_oe_n;
  } state_t;

  state_t q;
  state_t n;
  logic lock;
  logic accept;
  logic status_reset_request;
  logic cs_rise;
  logic [11:0] want_on;
  logic [11:0] tgt_hs;
  logic [11:0] tgt_ls;
  logic [11:0][1:0] hbst;
  logic [15:0] live;
  logic [11:0] grp_mask;

  frame_link_if lk ();

  spi_link_front u_front (
    .i_sclk(i_sclk),
    .i_csb_n(i_csb_n),
    .i_si(i_si),
    .i_nrst(i_nrst),
    .o_so(o_so),
    .lk(lk)
  );

  // --------------------------------------------------------------------------
  // per-channel output decision and status code
  // --------------------------------------------------------------------------
  // undervoltage always locks; overvoltage only with the lockout enable set
  assign lock = q.uv_s[1] | (q.ov_s[1] & q.overvoltage_lockout_enable); // R3 R16 R19 R20

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    // stored command gated by latched faults and by the live lockout
    assign want_on[c] = q.en_cmd[c] & ~q.ocs_l[c] & ~q.tsd_l[c] & ~(q.uld_l[c] & q.underload_shutdown_enable)
                        & ~lock & q.en_s[1]; // R2 R4 R7 R9
    assign tgt_hs[c] = want_on[c] & q.dir_cmd[c];
    assign tgt_ls[c] = want_on[c] & ~q.dir_cmd[c];
    // overcurrent outranks underload, which outranks the plain on/off report
    assign hbst[c] = q.ocs_l[c] ? bfs_pkg::HB_OCS :
                     q.uld_l[c] ? bfs_pkg::HB_ULD :
                     (q.drv_hs[c] | q.drv_ls[c]) ? bfs_pkg::HB_ON : bfs_pkg::HB_OFF;
  end

  // --------------------------------------------------------------------------
  // live status word for the selected group
  // --------------------------------------------------------------------------
  for (genvar i = 0; i < GRP; i++) begin : g_st
    assign live[bfs_pkg::ST_HB_LSB + 2*i +: 2] = q.sel ? hbst[GRP + i] : hbst[i]; // R10
  end
  assign live[bfs_pkg::ST_TW] = |q.tw_s[1];
  assign live[bfs_pkg::ST_ULD] = |q.uld_l;
  assign live[bfs_pkg::ST_PSF] = q.uv_s[1] | q.ov_s[1]; // R8 R16 R19 R20
  assign live[bfs_pkg::ST_OCS] = |q.ocs_l;

  // --------------------------------------------------------------------------
  // frame acceptance
  // --------------------------------------------------------------------------
  // the link clock is idle once chip select is high, so the received word is still
  assign cs_rise = q.cs_s[1] & ~q.cs_prev;
  assign accept = cs_rise & (lk.frame_id != q.seen_id) & lk.frame_ok & q.en_s[1]; // R2 R23
  // a request inside the interval is ignored rather than queued
  assign status_reset_request = accept & lk.rx_word[bfs_pkg::CMD_SRR] & (q.srr_cnt == '0); // R12 R13
  assign grp_mask = lk.rx_word[bfs_pkg::CMD_SEL] ? 12'hfc0 : 12'h03f;

  always_comb begin
    n = q;
    // two-stage synchronisers for every asynchronous level
    n.cs_s = {q.cs_s[0], i_csb_n};
    n.en_s = {q.en_s[0], i_en};
    n.uv_s = {q.uv_s[0], i_supply_uv};
    n.ov_s = {q.ov_s[0], i_supply_ov};
    n.oc_s = {q.oc_s[0], i_overcurrent};
    n.ul_s = {q.ul_s[0], i_underload};
    n.tw_s = {q.tw_s[0], i_thermal_warn};
    n.ts_s = {q.ts_s[0], i_thermal_sd};
    n.cs_prev = q.cs_s[1];
    n.so_oe_n = q.cs_s[1];
    if (cs_rise) begin
      n.seen_id = lk.frame_id;
    end

    // command store; kept through any lockout
    if (accept) begin
      n.sel = lk.rx_word[bfs_pkg::CMD_SEL]; // R10
      n.underload_shutdown_enable = lk.rx_word[bfs_pkg::CMD_UNDERLOAD_SHUTDOWN_ENABLE];
      n.overvoltage_lockout_enable = lk.rx_word[bfs_pkg::CMD_OVERVOLTAGE_LOCKOUT_ENABLE];
      if (lk.rx_word[bfs_pkg::CMD_SEL]) begin
        n.en_cmd[GRP +: GRP] = lk.rx_word[bfs_pkg::CMD_EN_LSB +: GRP]; // R9 R17 R21
        n.dir_cmd[GRP +: GRP] = lk.rx_word[bfs_pkg::CMD_CFG_LSB +: GRP];
      end else begin
        n.en_cmd[0 +: GRP] = lk.rx_word[bfs_pkg::CMD_EN_LSB +: GRP];
        n.dir_cmd[0 +: GRP] = lk.rx_word[bfs_pkg::CMD_CFG_LSB +: GRP];
      end
    end

    // latched faults: a present fault wins over a same-cycle clear
    if (!q.en_s[1]) begin
      n.ocs_l = '0; // R15
      n.uld_l = '0;
      n.tsd_l = '0;
    end else begin
      n.ocs_l = (q.ocs_l & ~(status_reset_request ? grp_mask : 12'h000)) | q.oc_s[1]; // R7 R12 R14
      n.tsd_l = (q.tsd_l & ~(status_reset_request ? grp_mask : 12'h000)) | q.ts_s[1]; // R24 R14
      // underload after an overcurrent is not reported until that clears
      n.uld_l = (q.uld_l & ~(status_reset_request ? grp_mask : 12'h000)) | (q.ul_s[1] & ~q.ocs_l); // R7 R12
    end

    // interval after a reset request
    if (status_reset_request) begin
      n.srr_cnt = bfs_pkg::SRR_CYC; // R13
    end else if (q.srr_cnt != '0) begin
      n.srr_cnt = q.srr_cnt - 1'b1;
    end

    // status snapshot: frozen while chip select is low, held after a reset request
    if (status_reset_request) begin
      n.hold = 1'b1;
    end else if (!q.cs_s[1]) begin
      n.hold = 1'b0;
    end
    if (!q.en_s[1]) begin
      n.snap = bfs_pkg::ST_RST; // R15
      n.snap_tsd = 1'b0;
    end else if (q.cs_s[1] && !n.hold) begin
      n.snap = live; // R11
      n.snap_tsd = |q.tsd_l;
    end

    // drivers: off at once, on only after the gap has run out
    for (int c = 0; c < NCH; c++) begin
      if (q.dt[c] != '0) begin
        n.dt[c] = q.dt[c] - 1'b1;
      end
      if ({q.drv_hs[c], q.drv_ls[c]} == {tgt_hs[c], tgt_ls[c]}) begin
        n.drv_hs[c] = q.drv_hs[c]; // R6
        n.drv_ls[c] = q.drv_ls[c];
      end else if (q.drv_hs[c] | q.drv_ls[c]) begin
        n.drv_hs[c] = 1'b0; // R5
        n.drv_ls[c] = 1'b0;
        n.dt[c] = bfs_pkg::DEAD_CYC;
      end else if (q.dt[c] == '0) begin
        n.drv_hs[c] = tgt_hs[c]; // R4 R5
        n.drv_ls[c] = tgt_ls[c];
      end
    end
  end

  // power-on reset doubles as logic-supply undervoltage
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '0; // R1 R18
      q.snap <= bfs_pkg::ST_RST;
      q.cs_s <= 2'h3;
      q.cs_prev <= 1'b1;
      q.so_oe_n <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign lk.status_word = q.snap;
  assign lk.tsd_flag = q.snap_tsd;
  assign o_so_oe_n = q.so_oe_n; // R1
  assign o_high_side_switch = q.drv_hs;
  assign o_low_side_switch = q.drv_ls;
  assign o_bridge_oe_n = ~(q.drv_hs | q.drv_ls); // R1 R3
  assign o_supply_fail_flag = q.snap[bfs_pkg::ST_PSF];
  assign o_srr_busy = (q.srr_cnt != '0);

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  no_shoot_through_a: assert property ((q.drv_hs & q.drv_ls) == 12'h000) // R5
    else $error("high and low side on together");

  dead_gap_a: assert property ($rose(q.drv_hs[0]) |->
    !$past(q.drv_ls[0], 1) && !$past(q.drv_ls[0], 2) && !$past(q.drv_ls[0], 3)) // R5
    else $error("no gap before high side on");

  uv_lockout_a: assert property (q.uv_s[1] |=> ((q.drv_hs | q.drv_ls) == 12'h000)) // R16
    else $error("outputs on during undervoltage");

  ov_lockout_a: assert property ((q.ov_s[1] && q.overvoltage_lockout_enable) |=>
    ((q.drv_hs | q.drv_ls) == 12'h000)) // R19
    else $error("outputs on during overvoltage lockout");

  cmd_kept_a: assert property (!accept |=> $stable(q.en_cmd) && $stable(q.dir_cmd)) // R3 R23
    else $error("command changed without a good frame");

  fault_off_a: assert property (1'b1 |=>
    ((q.drv_hs | q.drv_ls) & $past(q.ocs_l | q.tsd_l)) == 12'h000) // R4 R7
    else $error("faulted channel still driven");

  latch_hold_a: assert property ((!status_reset_request && q.en_s[1]) |=>
    ((q.ocs_l & $past(q.ocs_l)) == $past(q.ocs_l))) // R7
    else $error("latched fault lost without reset request");

  relatch_a: assert property (q.en_s[1] |=>
    ((q.ocs_l & $past(q.oc_s[1])) == $past(q.oc_s[1]))) // R14
    else $error("present overcurrent not latched");

  status_freeze_a: assert property ((!q.cs_s[1] && q.en_s[1]) |=> $stable(q.snap)) // R11
    else $error("status changed during a frame");

  srr_interval_a: assert property (status_reset_request |=> (q.srr_cnt == bfs_pkg::SRR_CYC) ##1 !status_reset_request) // R13
    else $error("reset interval not started");

  srr_gap_a: assert property ((q.srr_cnt != '0) |-> !status_reset_request) // R13
    else $error("reset request taken inside interval");

  en_clear_a: assert property (!q.en_s[1] |=>
    (q.ocs_l == 12'h000) && (q.tsd_l == 12'h000) && (q.snap == 16'h0000)) // R15
    else $error("status kept with enable low");

  psf_flag_a: assert property ((q.uv_s[1] && q.cs_s[1] && !q.hold && q.en_s[1] && !status_reset_request)
    |=> q.snap[bfs_pkg::ST_PSF]) // R16
    else $error("supply fail flag missing");
endmodule : bridge_fault_supervisor

// ==== tb/spi_host_model.sv ====
// partner: serial host that frames commands and collects the status word
// assumes the device samples data on the rising link clock edge
module spi_host_model (
  // link pins
  output logic o_sclk,
  output logic o_sel_n,
  output logic o_si,
  input wire logic i_so,
  input wire logic i_so_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] rx_q;
  logic hot_q;
  logic line;
  // a released output must not look like valid data
  assign line = i_so_oe_n ? ~i_so : i_so;
  initial begin
    o_sclk = 1'b0;
    o_sel_n = 1'b1;
    o_si = 1'b0;
    rx_q = 16'h0000;
    hot_q = 1'b0;
  end
  // link clock toggles only inside a frame, 80 ns period
  task automatic xfer(input logic [23:0] word, input int nbits);
    o_sel_n = 1'b0;
    #500;
    hot_q = line;
    for (int k = nbits - 1; k >= 0; k--) begin
      o_si = word[k];
      #40;
      o_sclk = 1'b1;
      #40;
      o_sclk = 1'b0;
      rx_q = {rx_q[14:0], line};
    end
    #40;
    o_si = 1'b0;
    o_sel_n = 1'b1;
    // gap before the next frame is well over four core clocks
    #600;
  endtask : xfer
endmodule : spi_host_model

// ==== tb/bridge_fault_supervisor_tb.sv ====
// self-checking bench for the bridge fault supervisor
// assumes the host model frames every command; the host resends its pattern each frame
module bridge_fault_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk, i_nrst, i_en, i_sclk, i_csb_n, i_si, o_so, o_so_oe_n;
  logic i_supply_uv, i_supply_ov, o_supply_fail_flag, o_srr_busy;
  logic [11:0] i_overcurrent, i_underload, i_thermal_warn, i_thermal_sd;
  logic [11:0] o_high_side_switch, o_low_side_switch, o_bridge_oe_n;
  logic [15:0] w0, rq;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int gap = 0;
  int last_gap = 0;

  bridge_fault_supervisor u_dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_en(i_en), .i_sclk(i_sclk),
    .i_csb_n(i_csb_n), .i_si(i_si), .o_so(o_so), .o_so_oe_n(o_so_oe_n),
    .i_supply_uv(i_supply_uv), .i_supply_ov(i_supply_ov),
    .i_overcurrent(i_overcurrent), .i_underload(i_underload),
    .i_thermal_warn(i_thermal_warn), .i_thermal_sd(i_thermal_sd),
    .o_high_side_switch(o_high_side_switch), .o_low_side_switch(o_low_side_switch),
    .o_bridge_oe_n(o_bridge_oe_n), .o_supply_fail_flag(o_supply_fail_flag),
    .o_srr_busy(o_srr_busy));
  spi_host_model u_host (
    .o_sclk(i_sclk), .o_sel_n(i_csb_n), .o_si(i_si), .i_so(o_so), .i_so_oe_n(o_so_oe_n));

  initial i_clk = 1'b0;
  always #50 i_clk = ~i_clk;

  // ----
  // helpers
  // ----
  function automatic logic [15:0] mk(input logic grp, input logic [5:0] en,
      input logic [5:0] cfg, input logic ov);
    return {1'b0, grp, 1'b0, en, cfg, ov};
  endfunction : mk

  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic outs(input logic [11:0] hs, input logic [11:0] ls);
    check("high side", {4'h0, o_high_side_switch}, {4'h0, hs});
    check("low side", {4'h0, o_low_side_switch}, {4'h0, ls});
    check("bridge oe_n", {4'h0, o_bridge_oe_n}, {4'h0, ~(hs | ls)});
  endtask : outs

  task automatic frame(input logic [23:0] word, input int nbits);
    u_host.xfer(word, nbits);
    repeat (20) @(negedge i_clk);
  endtask : frame

  task automatic wait_idle();
    int n;
    n = 0;
    while (o_srr_busy !== 1'b0 && n < 1200) begin
      @(negedge i_clk);
      n++;
    end
    check("busy", {15'h0, o_srr_busy}, 16'h0000);
  endtask : wait_idle

  task automatic supply_case(input logic uv, input logic ov, input logic [15:0] mid,
      input logic [11:0] hs_m, input logic [11:0] ls_m,
      input logic [11:0] hs_e, input logic [11:0] ls_e);
    i_supply_uv = uv;
    i_supply_ov = ov;
    repeat (10) @(negedge i_clk);
    frame(mid, 16);
    outs(hs_m, ls_m);
    check("supply fail", {15'h0, o_supply_fail_flag}, 16'h0001);
    check("status fail bit", {15'h0, u_host.rx_q[14]}, 16'h0001);
    i_supply_uv = 1'b0;
    i_supply_ov = 1'b0;
    repeat (20) @(negedge i_clk);
    outs(hs_e, ls_e);
    check("supply fail", {15'h0, o_supply_fail_flag}, 16'h0000);
  endtask : supply_case

  // shoot-through watch and off gap between drives on channel 0
  always @(negedge i_clk) begin
    if (i_nrst === 1'b1) begin
      check("overlap", {4'h0, o_high_side_switch & o_low_side_switch}, 16'h0000);
    end
    if (o_high_side_switch[0] | o_low_side_switch[0]) begin
      if (gap != 0) last_gap = gap;
      gap = 0;
    end else begin
      gap++;
    end
  end

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      $display("BAD timeout expected end seen hang");
      complete_run();
    end
  end

  // ----
  // sequence
  // ----
  initial begin
    i_nrst = 1'b0;
    i_en = 1'b1;
    i_supply_uv = 1'b0;
    i_supply_ov = 1'b0;
    i_overcurrent = 12'h000;
    i_underload = 12'h000;
    i_thermal_warn = 12'h000;
    i_thermal_sd = 12'h000;
    w0 = mk(1'b0, 6'h3f, 6'h15, 1'b1);
    repeat (10) @(negedge i_clk);
    outs(12'h000, 12'h000);
    check("serial oe_n", {15'h0, o_so_oe_n}, 16'h0001);
    i_nrst = 1'b1;
    repeat (5) @(negedge i_clk);
    frame(w0, 16);
    check("status", u_host.rx_q, 16'h0000);
    frame(mk(1'b1, 6'h0f, 6'h03, 1'b1), 16);
    outs(12'h0d5, 12'h32a);
    frame(mk(1'b1, 6'h0f, 6'h03, 1'b1), 16);
    check("status", u_host.rx_q, 16'h01fe);
    last_gap = 0;
    w0 = mk(1'b0, 6'h3f, 6'h14, 1'b1);
    rq = w0 | 16'h8000;
    frame(w0, 16);
    outs(12'h0d4, 12'h32b);
    check("gap", {15'h0, last_gap >= 10}, 16'h0001);
    frame(mk(1'b0, 6'h00, 6'h00, 1'b1), 15);
    outs(12'h0d4, 12'h32b);
    frame({8'ha5, mk(1'b0, 6'h01, 6'h01, 1'b1)}, 24);
    outs(12'h0c1, 12'h300);
    frame(w0, 16);
    supply_case(1'b1, 1'b0, mk(1'b0, 6'h01, 6'h01, 1'b1), 12'h000, 12'h000,
      12'h0c1, 12'h300);
    frame(w0, 16);
    supply_case(1'b0, 1'b1, mk(1'b0, 6'h01, 6'h01, 1'b1), 12'h000, 12'h000,
      12'h0c1, 12'h300);
    frame(w0 & 16'hfffe, 16);
    supply_case(1'b0, 1'b1, w0 & 16'hfffe, 12'h0d4, 12'h32b, 12'h0d4, 12'h32b);
    frame(w0, 16);
    i_overcurrent[1] = 1'b1;
    i_thermal_warn[4] = 1'b1;
    repeat (10) @(negedge i_clk);
    i_overcurrent[1] = 1'b0;
    repeat (10) @(negedge i_clk);
    outs(12'h0d4, 12'h329);
    frame(w0, 16);
    check("status", u_host.rx_q, 16'h9fef);
    frame(rq, 16);
    outs(12'h0d4, 12'h32b);
    check("busy", {15'h0, o_srr_busy}, 16'h0001);
    i_overcurrent[1] = 1'b1;
    i_thermal_warn[4] = 1'b0;
    repeat (10) @(negedge i_clk);
    i_overcurrent[1] = 1'b0;
    frame(rq, 16);
    outs(12'h0d4, 12'h329);
    wait_idle();
    i_overcurrent[1] = 1'b1;
    frame(rq, 16);
    outs(12'h0d4, 12'h329);
    i_overcurrent[1] = 1'b0;
    i_en = 1'b0;
    repeat (10) @(negedge i_clk);
    outs(12'h000, 12'h000);
    frame(mk(1'b0, 6'h00, 6'h00, 1'b1), 16);
    i_en = 1'b1;
    repeat (10) @(negedge i_clk);
    outs(12'h0d4, 12'h32b);
    frame(w0, 16);
    check("status", u_host.rx_q, 16'h1ffe);
    i_thermal_sd[2] = 1'b1;
    repeat (10) @(negedge i_clk);
    i_thermal_sd[2] = 1'b0;
    repeat (5) @(negedge i_clk);
    outs(12'h0d0, 12'h32b);
    frame(w0, 16);
    check("shutdown flag", {15'h0, u_host.hot_q}, 16'h0001);
    wait_idle();
    frame(rq, 16);
    outs(12'h0d4, 12'h32b);
    // underload with shutdown enabled latches channel 5 off
    frame(w0 | 16'h2000, 16);
    i_underload[5] = 1'b1;
    repeat (10) @(negedge i_clk);
    i_underload[5] = 1'b0;
    repeat (10) @(negedge i_clk);
    outs(12'h0d4, 12'h30b);
    frame(w0 | 16'h2000, 16);
    check("status", u_host.rx_q, 16'h37fe);
    complete_run();
  end
endmodule : bridge_fault_supervisor_tb
